// ### hw/lfst_flash_ctrl.sv
// flash LED mode decoder, strobe safety timer and torch watchdog with an APB register slave
// assumes pclk is the internal oscillator; analog pins arrive asynchronous and are synchronised
`timescale 1ns/10ps
`default_nettype none
`include "lfst_params.svh"
module lfst_flash_ctrl
	import lfst_pkg::*;
#(
	parameter int unsigned DC_WDOG_CYCLES    = `LFST_DC_WDOG_MS * `LFST_CLK_KHZ,
	parameter int unsigned FLASH_STEP_CYCLES = `LFST_FLASH_STEP_MS * `LFST_CLK_KHZ
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// pins and analog status, asynchronous
	input  wire logic        strobe_in,
	input  wire logic        force_voltage_regulation_pin,
	input  wire logic        tx_mask_in,
	input  wire logic        storage_cap_mode_select,
	input  wire logic        down_conversion_in,
	input  wire logic        led_short_in,
	input  wire logic        led_open_in,
	// power stage controls
	output logic             converter_enable,
	output logic [2:0]       led_sink_enable,
	output logic             flash_current_sel,
	output logic             torch_current_sel,
	output logic [3:0]       torch_current_level,
	output logic             voltage_regulation,
	output logic             fixed_preset_sel,
	output logic [3:0]       output_voltage_code,
	output logic             pulse_skip_enable,
	output logic [1:0]       current_limit_code,
	output logic             ovp_high_sel,
	output logic             short_current_limit,
	output logic             open_voltage_clamp,
	output logic             led_fault_flag
);

	lfst_state_t st_ff;
	lfst_state_t nxt_st;

	logic        ss_strobe;
	logic        vm_on;
	logic        trig;
	logic        rise;
	logic        flash_mode;
	logic        torch_lvl;
	logic        ctrl_wr;
	logic        stat_wr;
	logic        leds_on;
	logic        setup;
	logic [31:0] dur;
	logic [31:0] rdmux;

	always_comb begin
		nxt_st = st_ff;
		ss_strobe = st_ff.sync2[`LFST_SI_STROBE];
		vm_on = st_ff.sync2[`LFST_SI_VMPIN] | st_ff.vm_sw;
		trig = ss_strobe | st_ff.soft_flash_start;
		rise = (ss_strobe & ~st_ff.strobe_d) | (st_ff.soft_flash_start & ~st_ff.sft_d);
		flash_mode = (st_ff.mode == `LFST_MODE_FLASH);
		torch_lvl = (st_ff.mode == `LFST_MODE_TORCH) | (flash_mode & (st_ff.fl != FL_RUN));
		leds_on = (st_ff.mode == `LFST_MODE_TORCH) | flash_mode;
		setup = psel & ~penable;
		ctrl_wr = psel & penable & st_ff.pready & pwrite & (paddr == `LFST_ADDR_CTRL);
		stat_wr = psel & penable & st_ff.pready & pwrite & (paddr == `LFST_ADDR_STATUS);
		dur = 32'(({29'h0, st_ff.tsel} + 32'h1) * FLASH_STEP_CYCLES);
		rdmux = 32'h0;

		// second stage only reads the first
		nxt_st.sync1 = {led_open_in, led_short_in, down_conversion_in, storage_cap_mode_select,
			tx_mask_in, force_voltage_regulation_pin, strobe_in};
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.strobe_d = ss_strobe;
		nxt_st.sft_d = st_ff.soft_flash_start;

		// register file: answer with one access cycle, unmapped gives an error
		case (paddr)
			`LFST_ADDR_CTRL: begin
				rdmux[`LFST_C_MODE_LO +: 2] = st_ff.mode;
				rdmux[`LFST_C_VMSW] = st_ff.vm_sw;
				rdmux[`LFST_C_STT] = st_ff.strobe_trigger_type;
				rdmux[`LFST_C_PSM] = st_ff.psm_en;
				rdmux[`LFST_C_SFT] = st_ff.soft_flash_start;
				rdmux[`LFST_C_INDUCTOR_LIMIT_SELECT] = st_ff.inductor_limit_select;
			end
			`LFST_ADDR_LEVEL: begin
				rdmux[`LFST_L_OVC_LO +: 4] = st_ff.ovc;
				rdmux[`LFST_L_TSEL_LO +: 3] = st_ff.tsel;
				rdmux[`LFST_L_TORCH_LO +: 4] = st_ff.torch;
			end
			`LFST_ADDR_STATUS: begin
				rdmux[`LFST_S_FAULT] = st_ff.fault;
				rdmux[`LFST_S_EXPIRED] = st_ff.expired;
				rdmux[`LFST_S_WTRIP] = st_ff.wtrip;
				rdmux[`LFST_S_FLASH] = (st_ff.fl == FL_RUN);
				rdmux[`LFST_S_STARTED] = st_ff.started;
				rdmux[`LFST_S_VREG] = st_ff.vreg;
				rdmux[`LFST_S_INDUCTOR_LIMIT_SELECT_LO +: 2] = st_ff.inductor_limit_select_code;
				rdmux[`LFST_S_OVPHI] = st_ff.ovp_hi;
			end
			default: rdmux = 32'h0;
		endcase
		nxt_st.pready = setup;
		nxt_st.pslverr = setup & (paddr != `LFST_ADDR_CTRL) & (paddr != `LFST_ADDR_LEVEL)
			& (paddr != `LFST_ADDR_STATUS);
		nxt_st.prdata = (setup & ~pwrite) ? rdmux : 32'h0;

		// status clears first so a same-cycle hardware set wins
		if (stat_wr) begin
			if (pwdata[`LFST_S_FAULT])
				nxt_st.fault = 1'b0;
			if (pwdata[`LFST_S_EXPIRED])
				nxt_st.expired = 1'b0;
			if (pwdata[`LFST_S_WTRIP])
				nxt_st.wtrip = 1'b0;
		end

		// safety timer, one count per oscillator cycle
		case (st_ff.fl)
			FL_IDLE: begin
				if (flash_mode & rise) begin
					nxt_st.fl = FL_RUN;
					nxt_st.fcnt = dur;
				end
			end
			FL_RUN: begin
				if (!flash_mode) begin
					nxt_st.fl = FL_IDLE;
				end else if (st_ff.fcnt <= 32'h1) begin
					nxt_st.fl = FL_IDLE;
					nxt_st.soft_flash_start = 1'b0;
					nxt_st.expired = 1'b1;
				end else if (!st_ff.strobe_trigger_type && !trig) begin
					nxt_st.fl = FL_IDLE;
				end else begin
					nxt_st.fcnt = st_ff.fcnt - 32'h1;
				end
			end
			default: nxt_st.fl = FL_IDLE;
		endcase

		// torch watchdog, refreshed by any write to the control word
		if (!torch_lvl || ctrl_wr) begin
			nxt_st.wcnt = 32'h0;
		end else if (st_ff.wcnt >= DC_WDOG_CYCLES - 32'h1) begin
			nxt_st.wcnt = 32'h0;
			nxt_st.mode = `LFST_MODE_OFF;
			nxt_st.wtrip = 1'b1;
		end else begin
			nxt_st.wcnt = st_ff.wcnt + 32'h1;
		end

		// software writes last so a start written as the timer expires is kept
		if (ctrl_wr) begin
			nxt_st.mode = pwdata[`LFST_C_MODE_LO +: 2];
			nxt_st.vm_sw = pwdata[`LFST_C_VMSW];
			nxt_st.strobe_trigger_type = pwdata[`LFST_C_STT];
			nxt_st.psm_en = pwdata[`LFST_C_PSM];
			nxt_st.soft_flash_start = pwdata[`LFST_C_SFT];
			if (!st_ff.started)
				nxt_st.inductor_limit_select = pwdata[`LFST_C_INDUCTOR_LIMIT_SELECT];
		end
		if (psel & penable & st_ff.pready & pwrite & (paddr == `LFST_ADDR_LEVEL)) begin
			nxt_st.ovc = pwdata[`LFST_L_OVC_LO +: 4];
			nxt_st.tsel = pwdata[`LFST_L_TSEL_LO +: 3];
			nxt_st.torch = pwdata[`LFST_L_TORCH_LO +: 4];
		end
		// once running the limit is frozen; only reset brings back the initial state
		if (st_ff.mode != `LFST_MODE_OFF || vm_on)
			nxt_st.started = 1'b1;

		// power stage outputs
		nxt_st.conv_en = (st_ff.mode != `LFST_MODE_OFF) | vm_on;
		nxt_st.vreg = vm_on | (st_ff.mode == `LFST_MODE_VOLT);
		nxt_st.preset = st_ff.sync2[`LFST_SI_VMPIN];
		nxt_st.sinks = leds_on ? 3'h7 : 3'h0;
		nxt_st.flash_on = flash_mode & (st_ff.fl == FL_RUN);
		nxt_st.torch_on = torch_lvl;
		nxt_st.pskip = st_ff.psm_en | st_ff.sync2[`LFST_SI_DOWN];
		nxt_st.inductor_limit_select_code = {st_ff.sync2[`LFST_SI_STCAP] & st_ff.sync2[`LFST_SI_TXMASK],
			st_ff.inductor_limit_select};
		nxt_st.ovp_hi = st_ff.sync2[`LFST_SI_STCAP] | (st_ff.ovc > `LFST_OVC_LOW_MAX);
		nxt_st.ishort = st_ff.sync2[`LFST_SI_SHORT] & leds_on;
		nxt_st.vclamp = st_ff.sync2[`LFST_SI_OPEN] & leds_on;
		if (nxt_st.ishort | nxt_st.vclamp)
			nxt_st.fault = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.fl <= FL_IDLE;
			st_ff.mode <= `LFST_MODE_OFF;
			st_ff.ovc <= `LFST_OVC_RST;
			st_ff.tsel <= `LFST_TSEL_RST;
			st_ff.torch <= `LFST_TORCH_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign prdata = st_ff.prdata;
	assign converter_enable = st_ff.conv_en;
	assign led_sink_enable = st_ff.sinks;
	assign flash_current_sel = st_ff.flash_on;
	assign torch_current_sel = st_ff.torch_on;
	assign torch_current_level = st_ff.torch;
	assign voltage_regulation = st_ff.vreg;
	assign fixed_preset_sel = st_ff.preset;
	assign output_voltage_code = st_ff.ovc;
	assign pulse_skip_enable = st_ff.pskip;
	assign current_limit_code = st_ff.inductor_limit_select_code;
	assign ovp_high_sel = st_ff.ovp_hi;
	assign short_current_limit = st_ff.ishort;
	assign open_voltage_clamp = st_ff.vclamp;
	assign led_fault_flag = st_ff.fault;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence flash_launch;
		flash_mode && st_ff.fl == FL_IDLE && rise;
	endsequence
	sequence flash_runs;
		st_ff.fl == FL_RUN ##1 flash_current_sel;
	endsequence

	pskip_enable_a: assert property (st_ff.psm_en |=> pulse_skip_enable)
		else $error("pulse skipping not on with enable set");
	pskip_down_a: assert property (st_ff.sync2[`LFST_SI_DOWN] |=> pulse_skip_enable)
		else $error("pulse skipping off during down conversion");
	shut_mode_a: assert property ((st_ff.mode == `LFST_MODE_OFF && !vm_on) |=> !converter_enable)
		else $error("converter on in shutdown");
	torch_only_a: assert property (st_ff.mode == `LFST_MODE_TORCH |=>
		!flash_current_sel && torch_current_sel && led_sink_enable == 3'h7)
		else $error("flash current in torch mode");
	wdog_trip_a: assert property (torch_lvl && !ctrl_wr && st_ff.wcnt >= DC_WDOG_CYCLES - 32'h1
		|=> st_ff.mode == `LFST_MODE_OFF && st_ff.wtrip
		##1 (!converter_enable || voltage_regulation))
		else $error("torch watchdog did not shut down");
	volt_mode_a: assert property (st_ff.mode == `LFST_MODE_VOLT |=>
		led_sink_enable == 3'h0 && voltage_regulation && st_ff.fl == FL_IDLE)
		else $error("sinks or timer active in voltage mode");
	flash_start_a: assert property (flash_launch |=> flash_runs)
		else $error("trigger edge did not start flash");
	level_stop_a: assert property (st_ff.fl == FL_RUN && flash_mode && !st_ff.strobe_trigger_type && !trig
		&& st_ff.fcnt > 32'h1 |=> st_ff.fl == FL_IDLE ##1 !flash_current_sel)
		else $error("level flash did not stop on trigger low");
	sft_clear_a: assert property (st_ff.fl == FL_RUN && flash_mode && st_ff.fcnt <= 32'h1
		&& !ctrl_wr |=> !st_ff.soft_flash_start && st_ff.expired && st_ff.fl == FL_IDLE)
		else $error("timeout did not clear software start");
	oneshot_hold_a: assert property (st_ff.fl == FL_RUN && flash_mode && st_ff.strobe_trigger_type
		&& st_ff.fcnt > 32'h1 |=> st_ff.fl == FL_RUN && st_ff.fcnt == $past(st_ff.fcnt) - 32'h1)
		else $error("one-shot flash ended early");
	inductor_limit_select_lock_a: assert property (st_ff.started |=> $stable(st_ff.inductor_limit_select))
		else $error("limit select changed after start");
	ovp_sel_a: assert property (##1 ovp_high_sel == ($past(st_ff.sync2[`LFST_SI_STCAP])
		|| $past(st_ff.ovc) > `LFST_OVC_LOW_MAX))
		else $error("wrong over-voltage threshold");
	inductor_limit_select_code_a: assert property (st_ff.sync2[`LFST_SI_STCAP] && st_ff.sync2[`LFST_SI_TXMASK]
		|=> current_limit_code[1] && current_limit_code[0] == $past(st_ff.inductor_limit_select))
		else $error("reduced current limit not selected");
	fault_set_a: assert property ((st_ff.sync2[`LFST_SI_SHORT] || st_ff.sync2[`LFST_SI_OPEN])
		&& leds_on |=> led_fault_flag)
		else $error("led fault flag not set");
	preset_pin_a: assert property (st_ff.sync2[`LFST_SI_VMPIN] |=>
		fixed_preset_sel && voltage_regulation && converter_enable)
		else $error("voltage-mode pin did not force preset");
	flash_excl_a: assert property (flash_current_sel |->
		!torch_current_sel && led_sink_enable == 3'h7)
		else $error("flash and torch current selected together");
	sync_chain_a: assert property (##1 st_ff.sync2 == $past(st_ff.sync1))
		else $error("synchroniser second stage skipped");

endmodule
`default_nettype wire

// ### hw/lfst_params.svh
// offsets, field positions, reset values and timing counts of the flash mode and strobe timer
// assumes a 25 MHz pclk and 32-bit APB data
// Notes on behaviour
// - power-save enable bit turns light-load pulse skipping on or off.
// - during down conversion pulse skipping stays on whatever the enable bit says.
// - mode 00 without forced voltage mode means shutdown.
// - mode 01 drives torch current and ignores strobe and software start.
// - torch current needs a mode rewrite within 11.2 s, else shutdown.
// - mode 11 regulates voltage, disables all three sinks, safety timer off.
// - mode 10 takes a flash trigger from strobe pin or software start.
// - level mode: flash current while strobe or start high, torch otherwise.
// - level mode: rising edge of strobe or start starts the safety timer.
// - level mode: trigger low or timeout stops the timer and the flash.
// - timeout clears the software start bit.
// - three-bit timeout select limits the flash pulse length.
// - one-shot mode: rising edge launches flash, further triggers ignored until timeout.
// - safety timer runs on the internal clock, so duration tracks its frequency.
// - inductor limit select only takes effect in the initial shutdown state.
// - limit 1250/1750 mA by select, 250/500 mA with storage cap and tx mask.
// - shorted LED limits output current and sets the LED fault flag.
// - open LED clamps output at the active threshold and sets the fault flag.
// - low threshold when storage cap off and voltage code 0000..0100, else high.
// - voltage-mode pin forces voltage regulation at the fixed 4.95 V preset.
// - software force bit forces voltage regulation like the pin.
// - forced voltage mode with mode 00 or 11 turns LEDs off, regulates by code.
`ifndef LFST_PARAMS_SVH
`define LFST_PARAMS_SVH

`define LFST_ADDR_CTRL    12'h000
`define LFST_ADDR_LEVEL   12'h004
`define LFST_ADDR_STATUS  12'h008

// control word bits
`define LFST_C_MODE_LO    0
`define LFST_C_VMSW       2
`define LFST_C_STT        3
`define LFST_C_PSM        4
`define LFST_C_SFT        5
`define LFST_C_INDUCTOR_LIMIT_SELECT       6
// level word fields
`define LFST_L_OVC_LO     0
`define LFST_L_TSEL_LO    4
`define LFST_L_TORCH_LO   8
// status bits, 0..2 are write-one-to-clear
`define LFST_S_FAULT      0
`define LFST_S_EXPIRED    1
`define LFST_S_WTRIP      2
`define LFST_S_FLASH      3
`define LFST_S_STARTED    4
`define LFST_S_VREG       5
`define LFST_S_INDUCTOR_LIMIT_SELECT_LO    6
`define LFST_S_OVPHI      8

`define LFST_MODE_OFF     2'h0
`define LFST_MODE_TORCH   2'h1
`define LFST_MODE_FLASH   2'h2
`define LFST_MODE_VOLT    2'h3
`define LFST_OVC_LOW_MAX  4'h4
`define LFST_OVC_RST      4'h0
`define LFST_TSEL_RST     3'h0
`define LFST_TORCH_RST    4'h0

// synchroniser lanes
`define LFST_SYNC_W       7
`define LFST_SI_STROBE    0
`define LFST_SI_VMPIN     1
`define LFST_SI_TXMASK    2
`define LFST_SI_STCAP     3
`define LFST_SI_DOWN      4
`define LFST_SI_SHORT     5
`define LFST_SI_OPEN      6

`define LFST_CLK_KHZ      25000
`define LFST_DC_WDOG_MS   11200
`define LFST_FLASH_STEP_MS 50

`endif

// ### hw/lfst_pkg.sv
// types of the flash mode and strobe timer
// assumes lfst_params.svh for widths
`include "lfst_params.svh"
package lfst_pkg;

	typedef enum logic [1:0] {
		FL_IDLE = 2'b01,
		FL_RUN  = 2'b10
	} lfst_flash_t;

	typedef struct packed {
		logic [`LFST_SYNC_W-1:0] sync1;
		logic [`LFST_SYNC_W-1:0] sync2;
		logic                    strobe_d;
		logic                    sft_d;
		logic [1:0]              mode;
		logic                    vm_sw;
		logic                    strobe_trigger_type;
		logic                    psm_en;
		logic                    soft_flash_start;
		logic                    inductor_limit_select;
		logic                    started;
		logic [3:0]              ovc;
		logic [2:0]              tsel;
		logic [3:0]              torch;
		logic                    fault;
		logic                    expired;
		logic                    wtrip;
		lfst_flash_t             fl;
		logic [31:0]             fcnt;
		logic [31:0]             wcnt;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
		logic                    conv_en;
		logic [2:0]              sinks;
		logic                    flash_on;
		logic                    torch_on;
		logic                    vreg;
		logic                    preset;
		logic                    pskip;
		logic [1:0]              inductor_limit_select_code;
		logic                    ovp_hi;
		logic                    ishort;
		logic                    vclamp;
	} lfst_state_t;

endpackage

// ### tb/led_flash_mode_and_strobe_timer_tb.sv
// self-checking bench for the flash mode decoder, strobe safety timer and watchdog
// assumes shortened timer parameters; the camera model drives the strobe pin
`timescale 1ns/10ps
`default_nettype none
`include "lfst_params.svh"
module led_flash_mode_and_strobe_timer_tb;
	import lfst_pkg::*;
	localparam int unsigned WDOG = 200;
	localparam int unsigned STEP = 10;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        vm_pin, txm, stcap, down, lshort, lopen;
	logic        conv, fsel, tsel_o, vreg, fps, pskip, ovph, ishort, vclamp, fault;
	logic [2:0]  sinks;
	logic [3:0]  tlev, ovc;
	logic [1:0]  lim;
	wire logic   strobe_in;
	int          err_count, n_compared, n;

	lfst_cam_model cam (.pclk(pclk), .strobe(strobe_in));

	lfst_flash_ctrl #(.DC_WDOG_CYCLES(WDOG), .FLASH_STEP_CYCLES(STEP)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.strobe_in(strobe_in), .force_voltage_regulation_pin(vm_pin), .tx_mask_in(txm),
		.storage_cap_mode_select(stcap), .down_conversion_in(down), .led_short_in(lshort),
		.led_open_in(lopen), .converter_enable(conv), .led_sink_enable(sinks),
		.flash_current_sel(fsel), .torch_current_sel(tsel_o), .torch_current_level(tlev),
		.voltage_regulation(vreg), .fixed_preset_sel(fps), .output_voltage_code(ovc),
		.pulse_skip_enable(pskip), .current_limit_code(lim), .ovp_high_sel(ovph),
		.short_current_limit(ishort), .open_voltage_clamp(vclamp), .led_fault_flag(fault)
	);

	always #20 pclk = ~pclk;

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [31:0] inr(input int v, input int lo, input int hi);
		return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
	endfunction

	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
	endtask

	// slave answers without wait states, but the wait stays bounded anyway
	task automatic apb(input int wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr[0];
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (pready !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: no pready", $time);
			conclude();
		end
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] cw(input int m, vm, strobe_trigger_type, psm, soft_flash_start, il);
		cw = 32'h0;
		cw[`LFST_C_MODE_LO +: 2] = m[1:0];
		cw[`LFST_C_VMSW] = vm[0];
		cw[`LFST_C_STT] = strobe_trigger_type[0];
		cw[`LFST_C_PSM] = psm[0];
		cw[`LFST_C_SFT] = soft_flash_start[0];
		cw[`LFST_C_INDUCTOR_LIMIT_SELECT] = il[0];
	endfunction

	function automatic logic [31:0] lw(input logic [3:0] ov, input logic [2:0] ts, input logic [3:0] tl);
		lw = {20'h0, tl, 1'b0, ts, ov};
	endfunction

	// cycles the flash select stays high, after at most 20 cycles of waiting for it
	task automatic flash_len(output int c);
		int i;
		c = 0;
		for (i = 0; i < 20 && fsel !== 1'b1; i++)
			@(posedge pclk);
		while (fsel === 1'b1 && c < 300) begin
			@(posedge pclk);
			c++;
		end
		if (c >= 300) begin
			err_count++;
			$display("unexpected at %0t: flash never ended", $time);
			conclude();
		end
	endtask

	task automatic t_reset();
		tick(1);
		chk({conv, sinks, vreg}, 32'h0, "reset outputs");
		apb(0, `LFST_ADDR_CTRL, 32'h0);
		chk(rd, 32'h0, "ctrl reset");
		apb(0, 12'hFFC, 32'h0);
		chk(last_err, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped read");
	endtask

	task automatic t_inductor_limit_select();
		apb(1, `LFST_ADDR_CTRL, cw(0, 0, 0, 0, 0, 1));
		tick(3);
		chk(lim, 32'h1, "limit select");
		txm <= 1'b1;
		stcap <= 1'b1;
		tick(5);
		chk(lim, 32'h3, "storage limit");
		txm <= 1'b0;
		stcap <= 1'b0;
		apb(1, `LFST_ADDR_CTRL, cw(1, 0, 0, 0, 0, 1));
		apb(1, `LFST_ADDR_CTRL, cw(0, 0, 0, 0, 0, 0));
		tick(5);
		chk(lim, 32'h1, "limit frozen");
	endtask

	task automatic t_modes();
		logic [2:0] tb [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		logic [5:0] ex [8] = '{6'h00, 6'h3E, 6'h3E, 6'h21, 6'h21, 6'h3F, 6'h3F, 6'h21};
		apb(1, `LFST_ADDR_LEVEL, lw(4'h0, 3'h0, 4'h9));
		for (int i = 0; i < 8; i++) begin
			apb(1, `LFST_ADDR_CTRL, cw(tb[i][1:0], tb[i][2], 0, 0, 0, 0));
			tick(3);
			chk({conv, sinks, tsel_o, vreg}, ex[i], "mode decode");
		end
		chk(tlev, 32'h9, "torch level");
		apb(1, `LFST_ADDR_CTRL, cw(1, 0, 0, 0, 1, 0));
		fork
			cam.fire(10);
			flash_len(n);
		join
		chk(n, 32'h0, "torch ignores triggers");
		apb(1, `LFST_ADDR_CTRL, cw(3, 0, 0, 0, 0, 0));
		apb(1, `LFST_ADDR_CTRL, cw(3, 0, 0, 0, 1, 0));
		flash_len(n);
		chk(n, 32'h0, "voltage mode no flash");
		apb(1, `LFST_ADDR_CTRL, cw(0, 0, 0, 0, 0, 0));
	endtask

	task automatic t_level();
		apb(1, `LFST_ADDR_LEVEL, lw(4'h0, 3'h3, 4'h9));
		apb(1, `LFST_ADDR_CTRL, cw(2, 0, 0, 0, 0, 0));
		apb(1, `LFST_ADDR_STATUS, 32'h7);
		fork
			cam.fire(100);
			flash_len(n);
		join
		chk(inr(n, 4 * STEP - 1, 4 * STEP + 1), 32'h1, "level timeout length");
		apb(0, `LFST_ADDR_STATUS, 32'h0);
		chk(rd[`LFST_S_EXPIRED], 32'h1, "expired set");
		apb(1, `LFST_ADDR_STATUS, 32'h7);
		fork
			cam.fire(8);
			flash_len(n);
		join
		chk(inr(n, 6, 10), 32'h1, "level follows strobe");
		apb(1, `LFST_ADDR_CTRL, cw(2, 0, 0, 0, 1, 0));
		flash_len(n);
		chk(inr(n, 4 * STEP - 2, 4 * STEP + 1), 32'h1, "soft start level");
		apb(0, `LFST_ADDR_CTRL, 32'h0);
		chk(rd[`LFST_C_SFT], 32'h0, "soft start cleared");
	endtask

	task automatic t_oneshot();
		apb(1, `LFST_ADDR_LEVEL, lw(4'h0, 3'h1, 4'h9));
		apb(1, `LFST_ADDR_CTRL, cw(2, 0, 1, 0, 0, 0));
		fork
			cam.fire(3);
			flash_len(n);
		join
		chk(inr(n, 2 * STEP - 1, 2 * STEP + 1), 32'h1, "one-shot strobe");
		apb(1, `LFST_ADDR_CTRL, cw(2, 0, 1, 0, 1, 0));
		fork
			flash_len(n);
			begin
				tick(8);
				cam.fire(4);
			end
		join
		chk(inr(n, 2 * STEP - 2, 2 * STEP + 1), 32'h1, "one-shot retrigger");
		apb(0, `LFST_ADDR_CTRL, 32'h0);
		chk(rd[`LFST_C_SFT], 32'h0, "one-shot soft cleared");
	endtask

	task automatic t_wdog();
		apb(1, `LFST_ADDR_CTRL, cw(1, 0, 0, 0, 0, 0));
		tick(WDOG * 3 / 4);
		apb(1, `LFST_ADDR_CTRL, cw(1, 0, 0, 0, 0, 0));
		tick(WDOG * 3 / 4);
		chk(conv, 32'h1, "refresh keeps torch");
		tick(WDOG / 2);
		chk({conv, sinks}, 32'h0, "watchdog shutdown");
		apb(0, `LFST_ADDR_STATUS, 32'h0);
		chk(rd[`LFST_S_WTRIP], 32'h1, "watchdog flag");
	endtask

	task automatic t_misc();
		vm_pin <= 1'b1;
		tick(5);
		chk({vreg, fps, conv, sinks}, 32'h38, "pin forces preset");
		vm_pin <= 1'b0;
		apb(1, `LFST_ADDR_LEVEL, lw(4'h4, 3'h0, 4'h9));
		tick(3);
		chk({ovph, ovc}, 32'h04, "low threshold");
		apb(1, `LFST_ADDR_LEVEL, lw(4'h5, 3'h0, 4'h9));
		tick(3);
		chk({ovph, ovc}, 32'h15, "high threshold");
		apb(1, `LFST_ADDR_LEVEL, lw(4'h4, 3'h0, 4'h9));
		stcap <= 1'b1;
		tick(5);
		chk(ovph, 32'h1, "storage threshold");
		stcap <= 1'b0;
		apb(1, `LFST_ADDR_CTRL, cw(1, 0, 0, 1, 0, 0));
		tick(3);
		chk(pskip, 32'h1, "power save on");
		apb(1, `LFST_ADDR_CTRL, cw(1, 0, 0, 0, 0, 0));
		tick(3);
		chk(pskip, 32'h0, "power save off");
		down <= 1'b1;
		tick(5);
		chk(pskip, 32'h1, "down conversion");
		down <= 1'b0;
		lshort <= 1'b1;
		tick(5);
		chk({ishort, fault}, 32'h3, "short fault");
		lshort <= 1'b0;
		apb(1, `LFST_ADDR_STATUS, 32'h7);
		apb(0, `LFST_ADDR_STATUS, 32'h0);
		chk(rd[`LFST_S_FAULT], 32'h0, "fault cleared");
		lopen <= 1'b1;
		tick(5);
		chk({vclamp, fault}, 32'h3, "open fault");
		lopen <= 1'b0;
	endtask

	// a mid-run reset must bring back the initial shutdown state with a free limit select
	task automatic t_rerst();
		presetn <= 1'b0;
		tick(2);
		chk({conv, sinks, fault, lim}, 32'h0, "mid-run reset outputs");
		presetn <= 1'b1;
		apb(1, `LFST_ADDR_CTRL, cw(0, 0, 0, 0, 0, 1));
		tick(3);
		chk(lim, 32'h1, "limit free after reset");
		chk({conv, sinks}, 32'h0, "still shut down");
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{vm_pin, txm, stcap, down, lshort, lopen} = '0;
		err_count = 0;
		n_compared = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_inductor_limit_select();
		t_modes();
		t_level();
		t_oneshot();
		t_wdog();
		t_misc();
		t_rerst();
		conclude();
	end
endmodule
`default_nettype wire

// ### tb/lfst_cam_model.sv
// camera module model: drives the strobe pin as a level, low between frames
// assumes the caller invokes fire() right after a rising pclk edge
`timescale 1ns/10ps
`default_nettype none
module lfst_cam_model (
	// clock
	input  wire logic pclk,
	// strobe toward the flash controller
	output var  logic strobe
);
	initial strobe = 1'b0;

	task automatic fire(input int n);
		strobe <= 1'b1;
		repeat (n) @(posedge pclk);
		strobe <= 1'b0;
	endtask
endmodule
`default_nettype wire
